// file: rtl/lkl2_pkg.sv
// Shared constants and types for the look-aside cache bus response block
package lkl2_pkg;

  // ----------------------------------------------------------------
  // Data path sizing
  // ----------------------------------------------------------------
  localparam int DATA_W     = 32;
  localparam int FIFO_DEPTH = 16;
  localparam int LINE_BEATS = 4;
  localparam int BEAT_W     = 3;
  localparam logic [BEAT_W-1:0] BEATS_LAST = 3'h3;
  localparam logic [BEAT_W-1:0] BEATS_DONE = 3'h4;

  // ----------------------------------------------------------------
  // Transfer type patterns, value and care mask, bit 4 is the first
  // ----------------------------------------------------------------
  localparam logic [4:0] TT_RD_BURST_V = 5'h0A;  // X1X10
  localparam logic [4:0] TT_RD_BURST_M = 5'h0B;
  localparam logic [4:0] TT_WR_BURST_V = 5'h06;  // 00110
  localparam logic [4:0] TT_EXACT_M    = 5'h1F;
  localparam logic [4:0] TT_WR_ANY_V   = 5'h02;  // 00X10
  localparam logic [4:0] TT_WR_ANY_M   = 5'h1B;
  localparam logic [4:0] TT_WR_SB_V    = 5'h02;  // 00010
  localparam logic [4:0] TT_LOW4_M     = 5'h0F;
  localparam logic [4:0] TT_RD_NC_V    = 5'h0A;  // X1010
  localparam logic [4:0] TT_WR_NC_V    = 5'h02;  // X0010
  localparam logic [4:0] TT_RWITM_V    = 5'h0E;  // X1110
  localparam logic [4:0] TT_FLUSH_V    = 5'h04;  // 00100
  localparam logic [4:0] TT_CLEAN_V    = 5'h00;  // 00000
  localparam logic [4:0] TT_KILL_V     = 5'h0C;  // 01100 / 0110X
  localparam logic [4:0] TT_KILL_X_M   = 5'h1E;
  localparam int         TT_READ_BIT   = 3;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       start;
    logic       chipset;
    logic [4:0] transferType;
    logic       burstIndicator;
    logic       cacheInhibit;
    logic       writeThroughAttr;
    logic       addressRetry;
    logic       transferAcknowledge;
    logic       cacheBusGrant;
    logic       processorBusRequest;
  } lkl2_pins_s;

  typedef struct packed {
    logic hit;
    logic dirty;
    logic victimDirty;
    logic castoutHit;
    logic castoutFull;
  } lkl2_tag_s;

  typedef struct packed {
    logic lineFill;
    logic castoutSupply;
    logic update;
    logic invalidate;
    logic clearDirty;
    logic restoreVictim;
    logic castoutInvalidate;
    logic writeBack;
  } lkl2_act_s;

  typedef struct packed {
    logic [4:0] transferType;
    logic       burstIndicator;
    logic       cacheInhibit;
    logic       writeThroughAttr;
  } lkl2_attr_s;

  typedef struct packed {
    logic valid;
    logic write;
    logic hit;
  } lkl2_snoop_s;

  localparam lkl2_attr_s COPYBACK_ATTR = '{5'h02, 1'b0, 1'b1, 1'b1};
  localparam lkl2_pins_s PINS_RESET    = '0;

  typedef enum logic [2:0] {
    ST_IDLE, ST_SERVE, ST_FILL, ST_RETRY, ST_PUSHREQ, ST_WAITGRANT, ST_PUSH
  } lkl2_state_e;

endpackage : lkl2_pkg

// file: rtl/lkl2_bus_response.sv
// Look-aside cache bus response logic with its write-back FIFO
`timescale 1ns/1ps
// How it works
// RL1 - Burst read hit claims; miss line-fills
// RL2 - Burst write miss fills unless after snoop hit or snoop write
// RL3 - Write-through burst write hit claims and acknowledges
// RL4 - Copy-back write hitting clean line updates
// RL5 - Copy-back burst write dirty hit updates, clears dirty
// RL6 - Single-beat dirty write hit: retry, push, clear dirty
// RL7 - Uncached read: invalidate clean, push dirty
// RL8 - Uncached write: invalidate clean, push dirty
// RL9 - Flush block: invalidate clean, push dirty
// RL10 - Clean block: push dirty, clear dirty bit
// RL11 - Kill block hit invalidates the tag
// RL12 - Dirty victim, full castout buffer cancels fill unless a burst write hits the castout buffer
// RL13 - Read hitting castout buffer served from it
// RL14 - Retry during dirty fill restores victim state
// RL15 - Write after snoop write: invalidate or no-allocate
// RL16 - Write after snoop read: update or allocate
// RL17 - Retry during read hit aborts service
// RL18 - Chipset flush/write/rwitm: invalidate or push
// RL19 - Chipset clean/read: push dirty, clear dirty
// RL20 - Processor request after retry window drops ours
// RL21 - Copyback drives fixed transfer attributes
// RL22 - Claim every hit the cache will satisfy

// ------------------------------------------------------------------
// Write-back FIFO
// ------------------------------------------------------------------
module lkl2_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             reset,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_q;
  logic [AW-1:0]    rdPtr_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  assign inReady  = (count_q != FULL_CNT);
  assign outValid = (count_q != '0);
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign outData  = mem[rdPtr_q];

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule : lkl2_fifo

// ------------------------------------------------------------------
// Bus response top
// ------------------------------------------------------------------
module lkl2_bus_response
  import lkl2_pkg::*;
(
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              reset,
  // Bus pins, asynchronous
  input  wire lkl2_pins_s        busPins,
  // Tag lookup and fill status, same clock
  input  wire lkl2_tag_s         tagLookup,
  input  wire logic              fillDone,
  // Write-back data from the array
  input  wire logic [DATA_W-1:0] wbData,
  input  wire logic              wbValid,
  output logic                   wbReady,
  // Bus response
  output logic                   hitClaim,
  output logic                   addressAcknowledgeOut,
  output logic                   addressAcknowledgeOe,
  output logic                   transferAcknowledgeOut,
  output logic                   transferAcknowledgeOe,
  output logic                   addressRetryOut,
  output logic                   addressRetryOe,
  output logic                   cacheBusRequest,
  // Copyback mastering
  output lkl2_attr_s             copybackAttr,
  output logic                   copybackAttrOe,
  output logic [DATA_W-1:0]      busDataOut,
  output logic                   busDataOe,
  // Tag array actions
  output lkl2_act_s              tagAction
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  lkl2_pins_s        syncA_q;
  lkl2_pins_s        pins_q;
  logic              startPrev_q;
  logic              start;
  lkl2_state_e       state_q;
  logic [BEAT_W-1:0] beat_q;
  lkl2_snoop_s       snoop_q;
  logic              pendInv_q;
  logic              pendClr_q;
  logic              victimDirty_q;
  logic              hitClaim_q;
  lkl2_act_s         tagAction_q;
  lkl2_act_s         dec;
  logic              decClaim;
  logic              decPush;
  logic              decPushInv;
  logic              decPushClr;
  logic              fillReq;
  logic              rdBurst;
  logic              wrBurst;
  logic              fifoValid;
  logic              pop;
  logic [4:0]        tt;

  function automatic logic ttIs(input logic [4:0] t, input logic [4:0] v,
                                input logic [4:0] m);
    return (t & m) == v;
  endfunction : ttIs

  // ----------------------------------------------------------------
  // Pin synchroniser and transfer start edge
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      syncA_q <= PINS_RESET;
      pins_q  <= PINS_RESET;
    end else begin
      syncA_q <= busPins;
      pins_q  <= syncA_q;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      startPrev_q <= 1'b0;
    end else begin
      startPrev_q <= pins_q.start;
    end
  end

  assign start   = pins_q.start && !startPrev_q && (state_q == ST_IDLE);
  assign tt      = pins_q.transferType;
  assign rdBurst = ttIs(tt, TT_RD_BURST_V, TT_RD_BURST_M) && !pins_q.burstIndicator
                   && pins_q.cacheInhibit;
  assign wrBurst = ttIs(tt, TT_WR_BURST_V, TT_EXACT_M) && !pins_q.burstIndicator
                   && pins_q.cacheInhibit;

  // ----------------------------------------------------------------
  // Response decision
  // ----------------------------------------------------------------
  always_comb begin
    dec        = '0;
    decClaim   = 1'b0;
    decPush    = 1'b0;
    decPushInv = 1'b0;
    decPushClr = 1'b0;
    fillReq    = 1'b0;
    if (pins_q.chipset) begin
      if (ttIs(tt, TT_KILL_V, TT_KILL_X_M) || ttIs(tt, TT_WR_BURST_V, TT_EXACT_M)) begin
        dec.invalidate = tagLookup.hit;  // [RL11]
      end else if (ttIs(tt, TT_FLUSH_V, TT_EXACT_M) || ttIs(tt, TT_WR_NC_V, TT_LOW4_M)
                   || ttIs(tt, TT_RWITM_V, TT_LOW4_M)) begin
        if (tagLookup.hit && tagLookup.dirty) begin
          decPush    = 1'b1;  // [RL18]
          decPushInv = 1'b1;
        end else begin
          dec.invalidate = tagLookup.hit;  // [RL18]
        end
      end else if (ttIs(tt, TT_CLEAN_V, TT_EXACT_M) || ttIs(tt, TT_RD_NC_V, TT_LOW4_M)) begin
        decPush    = tagLookup.hit && tagLookup.dirty;  // [RL19]
        decPushClr = tagLookup.hit && tagLookup.dirty;
      end
    end else if (rdBurst) begin
      decClaim = tagLookup.hit;  // [RL1] [RL22]
      fillReq  = !tagLookup.hit;  // [RL1]
    end else if (wrBurst) begin
      if (snoop_q.valid && snoop_q.hit) begin
        // Line just touched by a snoop: no claim, fix up the tag
        if (snoop_q.write) begin
          dec.invalidate = tagLookup.hit;  // [RL15]
        end else begin
          dec.update     = tagLookup.hit;  // [RL16]
          dec.clearDirty = tagLookup.hit;
        end
      end else if (!tagLookup.hit) begin
        fillReq = !(snoop_q.valid && snoop_q.write);  // [RL2] [RL15] [RL16]
      end else if (pins_q.writeThroughAttr) begin
        decClaim = 1'b1;  // [RL3] [RL22]
      end else begin
        dec.update     = 1'b1;  // [RL4] [RL5]
        dec.clearDirty = tagLookup.dirty;  // [RL5]
      end
    end else if (ttIs(tt, TT_WR_ANY_V, TT_WR_ANY_M) && pins_q.cacheInhibit
                 && !pins_q.writeThroughAttr && tagLookup.hit && !tagLookup.dirty) begin
      dec.update = 1'b1;  // [RL4]
    end else if (ttIs(tt, TT_WR_SB_V, TT_EXACT_M) && pins_q.burstIndicator
                 && pins_q.cacheInhibit && !pins_q.writeThroughAttr
                 && tagLookup.hit && tagLookup.dirty) begin
      decPush    = 1'b1;  // [RL6]
      decPushClr = 1'b1;
    end else if ((ttIs(tt, TT_RD_NC_V, TT_LOW4_M) || ttIs(tt, TT_WR_NC_V, TT_LOW4_M))
                 && pins_q.burstIndicator && !pins_q.cacheInhibit && tagLookup.hit) begin
      decPush        = tagLookup.dirty;  // [RL7] [RL8]
      decPushInv     = tagLookup.dirty;
      dec.invalidate = !tagLookup.dirty;  // [RL7] [RL8]
    end else if (ttIs(tt, TT_FLUSH_V, TT_EXACT_M) && tagLookup.hit) begin
      decPush        = tagLookup.dirty;  // [RL9]
      decPushInv     = tagLookup.dirty;
      dec.invalidate = !tagLookup.dirty;  // [RL9]
    end else if (ttIs(tt, TT_CLEAN_V, TT_EXACT_M) && tagLookup.hit) begin
      decPush    = tagLookup.dirty;  // [RL10]
      decPushClr = tagLookup.dirty;
    end else if (ttIs(tt, TT_KILL_V, TT_EXACT_M) && tagLookup.hit) begin
      dec.invalidate = 1'b1;  // [RL11]
    end
    if (fillReq) begin
      if (!wrBurst && tagLookup.castoutHit) begin
        dec.castoutSupply = 1'b1;  // [RL13]
      end else if (!(tagLookup.victimDirty && tagLookup.castoutFull)
                   || (wrBurst && tagLookup.castoutHit)) begin
        dec.lineFill = 1'b1;  // [RL12]
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_q <= ST_IDLE;
      beat_q  <= '0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          beat_q <= '0;
          if (start && decClaim) begin
            state_q <= ST_SERVE;
          end else if (start && decPush) begin
            state_q <= ST_RETRY;
          end else if (start && dec.lineFill) begin
            state_q <= ST_FILL;
          end
        end
        ST_SERVE: begin
          if (pins_q.addressRetry || beat_q == BEATS_DONE) begin
            state_q <= ST_IDLE;  // [RL17]
          end else begin
            beat_q <= beat_q + 1'b1;
          end
        end
        ST_FILL: begin
          if (pins_q.addressRetry || fillDone) begin
            state_q <= ST_IDLE;  // [RL14]
          end
        end
        ST_RETRY: begin
          state_q <= ST_PUSHREQ;
        end
        ST_PUSHREQ: begin
          // Processor wants the bus back: give up, it will retry
          state_q <= pins_q.processorBusRequest ? ST_IDLE : ST_WAITGRANT;  // [RL20]
        end
        ST_WAITGRANT: begin
          if (pins_q.cacheBusGrant) begin
            state_q <= ST_PUSH;
          end
        end
        ST_PUSH: begin
          if (pop) begin
            beat_q <= beat_q + 1'b1;
            if (beat_q == BEATS_LAST) begin
              state_q <= ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Per-transaction memory: snoop history and pending push action
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      snoop_q <= '0;
    end else if (start) begin
      snoop_q.valid <= pins_q.chipset;  // [RL15] [RL16]
      snoop_q.write <= !tt[TT_READ_BIT];
      snoop_q.hit   <= tagLookup.hit;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pendInv_q     <= 1'b0;
      pendClr_q     <= 1'b0;
      victimDirty_q <= 1'b0;
    end else if (start) begin
      pendInv_q     <= decPushInv;
      pendClr_q     <= decPushClr;
      victimDirty_q <= tagLookup.victimDirty;
    end
  end

  // ----------------------------------------------------------------
  // Claim level and tag action pulses
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      hitClaim_q <= 1'b0;
    end else if (start && decClaim) begin
      hitClaim_q <= 1'b1;  // [RL22]
    end else if (state_q == ST_SERVE && (pins_q.addressRetry || beat_q == BEATS_DONE)) begin
      hitClaim_q <= 1'b0;  // [RL17]
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      tagAction_q <= '0;
    end else begin
      tagAction_q <= '0;
      if (start) begin
        tagAction_q <= dec;
      end
      if (state_q == ST_FILL && pins_q.addressRetry && victimDirty_q) begin
        tagAction_q.restoreVictim     <= 1'b1;  // [RL14]
        tagAction_q.castoutInvalidate <= 1'b1;
      end
      if (state_q == ST_WAITGRANT && pins_q.cacheBusGrant) begin
        tagAction_q.writeBack <= 1'b1;
      end
      if (state_q == ST_PUSH && pop && beat_q == BEATS_LAST) begin
        tagAction_q.invalidate <= pendInv_q;  // [RL7] [RL9] [RL18]
        tagAction_q.clearDirty <= pendClr_q;  // [RL6] [RL10] [RL19]
      end
    end
  end

  // ----------------------------------------------------------------
  // Write-back data path and bus drive
  // ----------------------------------------------------------------
  assign pop = (state_q == ST_PUSH) && fifoValid && pins_q.transferAcknowledge;

  lkl2_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_wbFifo (
    .clock    (clock),
    .reset    (reset),
    .inValid  (wbValid),
    .inReady  (wbReady),
    .inData   (wbData),
    .outValid (fifoValid),
    .outReady (pop),
    .outData  (busDataOut)
  );

  assign hitClaim               = hitClaim_q;
  assign tagAction              = tagAction_q;
  assign addressAcknowledgeOut  = (state_q == ST_SERVE) && (beat_q == '0);  // [RL1] [RL3]
  assign addressAcknowledgeOe   = addressAcknowledgeOut;
  assign transferAcknowledgeOut = (state_q == ST_SERVE) && (beat_q != '0);
  assign transferAcknowledgeOe  = transferAcknowledgeOut;
  assign addressRetryOut        = (state_q == ST_RETRY);
  assign addressRetryOe         = addressRetryOut;
  assign cacheBusRequest        = (state_q == ST_RETRY) || (state_q == ST_WAITGRANT)
                                  || (state_q == ST_PUSHREQ && !pins_q.processorBusRequest);
  assign copybackAttr           = COPYBACK_ATTR;  // [RL21]
  assign copybackAttrOe         = (state_q == ST_PUSH);
  assign busDataOe              = (state_q == ST_PUSH) && fifoValid;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  property p_read_hit_claim;
    // A retried read is aborted and checked by its own property
    disable iff (reset || pins_q.addressRetry)
    start && !pins_q.chipset && rdBurst && tagLookup.hit
      |=> hitClaim && addressAcknowledgeOut ##1 transferAcknowledgeOut[*4];
  endproperty
  a_read_hit_claim: assert property (p_read_hit_claim)  // [RL1]
    else $error("read hit not claimed and acknowledged");

  property p_write_miss_fill;
    start && !pins_q.chipset && wrBurst && !tagLookup.hit && !snoop_q.valid
      && !tagLookup.victimDirty |=> tagAction.lineFill ##1 state_q == ST_FILL;
  endproperty
  a_write_miss_fill: assert property (p_write_miss_fill)  // [RL2]
    else $error("burst write miss did not line fill");

  property p_cancel_fill;
    start && rdBurst && !pins_q.chipset && !tagLookup.hit && !tagLookup.castoutHit
      && tagLookup.victimDirty && tagLookup.castoutFull |=> !tagAction.lineFill;
  endproperty
  a_cancel_fill: assert property (p_cancel_fill)  // [RL12]
    else $error("fill over dirty victim with full castout buffer");

  property p_castout_supply;
    start && rdBurst && !pins_q.chipset && !tagLookup.hit && tagLookup.castoutHit
      |=> tagAction.castoutSupply && !tagAction.lineFill;
  endproperty
  a_castout_supply: assert property (p_castout_supply)  // [RL13]
    else $error("castout hit not served from buffer");

  property p_fill_retry_restore;
    state_q == ST_FILL && pins_q.addressRetry && victimDirty_q
      |=> tagAction.restoreVictim && tagAction.castoutInvalidate && state_q == ST_IDLE;
  endproperty
  a_fill_retry_restore: assert property (p_fill_retry_restore)  // [RL14]
    else $error("retried fill did not restore victim");

  property p_read_abort;
    state_q == ST_SERVE && pins_q.addressRetry |=> state_q == ST_IDLE && !hitClaim;
  endproperty
  a_read_abort: assert property (p_read_abort)  // [RL17]
    else $error("retried read hit not aborted");

  property p_flush_push;
    start && !pins_q.chipset && ttIs(tt, TT_FLUSH_V, TT_EXACT_M) && tagLookup.hit
      && tagLookup.dirty |=> addressRetryOut && cacheBusRequest ##1 state_q == ST_PUSHREQ;
  endproperty
  a_flush_push: assert property (p_flush_push)  // [RL9]
    else $error("dirty flush hit not retried and pushed");

  property p_yield_bus;
    state_q == ST_PUSHREQ && pins_q.processorBusRequest
      |-> !cacheBusRequest ##1 (state_q == ST_IDLE && !copybackAttrOe);
  endproperty
  a_yield_bus: assert property (p_yield_bus)  // [RL20]
    else $error("bus request kept after processor request");

  property p_copyback_attr;
    busDataOe |-> copybackAttrOe && copybackAttr.transferType == 5'h02
      && !copybackAttr.burstIndicator && copybackAttr.cacheInhibit
      && copybackAttr.writeThroughAttr;
  endproperty
  a_copyback_attr: assert property (p_copyback_attr)  // [RL21]
    else $error("copyback attributes wrong");

  c_read_hit:   cover property (start && decClaim ##1 hitClaim);
  c_push_done:  cover property (state_q == ST_PUSH ##[1:40] state_q == ST_IDLE);
  c_yield:      cover property (state_q == ST_PUSHREQ && pins_q.processorBusRequest);
  c_fill_retry: cover property (state_q == ST_FILL && pins_q.addressRetry);

endmodule : lkl2_bus_response

// file: testbench/lkl2_bus_model.sv
// Arbiter and bus model that answers copyback requests
`timescale 1ns/1ps
module lkl2_bus_model (
  // Clock and reset
  input  wire logic clock,
  input  wire logic reset,
  // Request side
  input  wire logic slowGrant,
  input  wire logic cacheBusRequest,
  input  wire logic busDataOe,
  // Answers
  output logic      cacheBusGrant,
  output logic      transferAcknowledge
);
  logic [3:0] waitCount;

  // Grant only while requested, so a dropped request is never granted
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      waitCount     <= 4'h0;
      cacheBusGrant <= 1'b0;
    end else begin
      waitCount     <= cacheBusRequest ? waitCount + 4'h1 : 4'h0;
      cacheBusGrant <= cacheBusRequest && (waitCount >= (slowGrant ? 4'h8 : 4'h1));
    end
  end

  // One beat taken per cycle while the cache drives data
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      transferAcknowledge <= 1'b0;
    end else begin
      transferAcknowledge <= busDataOe;
    end
  end
endmodule : lkl2_bus_model

// file: testbench/lkl2_testbench.sv
// Self-checking bench for the bus response block
`timescale 1ns/1ps
module testbench import lkl2_pkg::*;;
  logic clock, reset, fillDone, wbValid, wbReady, grant, partnerTa, slowGrant, clr;
  logic hitClaim, address_acknowledge, aackOe, ta, taOe, retry, retryOe, busReq, attrOe, dataOe;
  logic seenClaim, seenRetry;
  logic [7:0] beats, lastWord;
  logic [DATA_W-1:0] wbData, busData;
  lkl2_pins_s pins, busPins;
  lkl2_tag_s  tagLookup;
  lkl2_attr_s attr, seenAttr;
  lkl2_act_s  tagAction, seenAct;
  int fails, samplesChecked, cycles;

  lkl2_bus_response dut (.clock(clock), .reset(reset), .busPins(busPins),
    .tagLookup(tagLookup), .fillDone(fillDone), .wbData(wbData), .wbValid(wbValid),
    .wbReady(wbReady), .hitClaim(hitClaim), .addressAcknowledgeOut(address_acknowledge),
    .addressAcknowledgeOe(aackOe), .transferAcknowledgeOut(ta), .transferAcknowledgeOe(taOe),
    .addressRetryOut(retry), .addressRetryOe(retryOe), .cacheBusRequest(busReq),
    .copybackAttr(attr), .copybackAttrOe(attrOe), .busDataOut(busData),
    .busDataOe(dataOe), .tagAction(tagAction));
  lkl2_bus_model partner (.clock(clock), .reset(reset), .slowGrant(slowGrant),
    .cacheBusRequest(busReq), .busDataOe(dataOe), .cacheBusGrant(grant),
    .transferAcknowledge(partnerTa));

  // Bus wires seen by the block combine our pins, its retry and the partner
  always_comb begin
    busPins = pins;
    busPins.addressRetry = pins.addressRetry | (retryOe & retry);
    busPins.transferAcknowledge = partnerTa;
    busPins.cacheBusGrant = grant;
  end

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // Collects every response seen during one transaction
  always @(posedge clock) begin
    seenAct   <= clr ? '0 : (seenAct | tagAction);
    seenClaim <= clr ? 1'b0 : (seenClaim | hitClaim);
    seenRetry <= clr ? 1'b0 : (seenRetry | (retryOe & retry & busReq));
    beats     <= clr ? 8'h00 : beats + {6'h00, address_acknowledge & aackOe, ta & taOe};
    lastWord  <= clr ? 8'hFF : (dataOe ? busData[7:0] : lastWord);
    if (attrOe) seenAttr <= attr;
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails++;
      endOfTest();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Start edge held long enough for a slow push to finish; ctl is retry, chipset, request
  task automatic run(input logic [4:0] tt, input logic [2:0] at, input lkl2_tag_s tag,
                     input logic [2:0] ctl, input logic [7:0] expAct, input logic [1:0] expF);
    @(negedge clock);
    clr = 1'b1;
    tagLookup = tag;
    pins.transferType = tt;
    {pins.burstIndicator, pins.cacheInhibit, pins.writeThroughAttr} = at;
    {pins.chipset, pins.processorBusRequest} = ctl[1:0];
    @(negedge clock);
    clr = 1'b0;
    pins.start = 1'b1;
    @(negedge clock);
    pins.addressRetry = ctl[2];
    repeat (9) @(negedge clock);
    fillDone = 1'b1;
    @(negedge clock);
    fillDone = 1'b0;
    repeat (30) @(negedge clock);
    pins = '0;
    chk(seenAct, expAct);
    chk({6'h00, seenClaim, seenRetry}, {6'h00, expF});
  endtask : run

  task automatic loadLine();
    for (int i = 0; i < LINE_BEATS; i++) begin
      @(negedge clock);
      wbValid = 1'b1;
      wbData = 32'hC0DE0000 + i;
    end
    @(negedge clock);
    wbValid = 1'b0;
  endtask : loadLine

  task automatic readCases();
    run(5'h0A, 3'h2, 5'h10, 3'h0, 8'h00, 2'h2);
    chk(beats, 8'h06);
    run(5'h0A, 3'h2, 5'h00, 3'h0, 8'h80, 2'h0);
    run(5'h0A, 3'h2, 5'h02, 3'h0, 8'h40, 2'h0);
    run(5'h0A, 3'h2, 5'h05, 3'h0, 8'h00, 2'h0);
    run(5'h0A, 3'h2, 5'h04, 3'h4, 8'h86, 2'h0);
    run(5'h0A, 3'h2, 5'h10, 3'h4, 8'h00, 2'h2);
    chk(beats, 8'h02);
  endtask : readCases

  task automatic writeCases();
    run(5'h02, 3'h6, 5'h10, 3'h0, 8'h20, 2'h0);
    run(5'h06, 3'h2, 5'h18, 3'h0, 8'h28, 2'h0);
    run(5'h06, 3'h2, 5'h00, 3'h0, 8'h80, 2'h0);
    run(5'h06, 3'h3, 5'h10, 3'h0, 8'h00, 2'h2);
    chk(beats, 8'h06);
    run(5'h0A, 3'h0, 5'h10, 3'h2, 8'h00, 2'h0);
    run(5'h06, 3'h3, 5'h18, 3'h0, 8'h28, 2'h0);
    run(5'h02, 3'h0, 5'h10, 3'h2, 8'h10, 2'h0);
    run(5'h06, 3'h2, 5'h10, 3'h0, 8'h10, 2'h0);
  endtask : writeCases

  task automatic addrOnlyCases();
    run(5'h0C, 3'h0, 5'h10, 3'h0, 8'h10, 2'h0);
    run(5'h0D, 3'h0, 5'h10, 3'h2, 8'h10, 2'h0);
    run(5'h00, 3'h0, 5'h10, 3'h0, 8'h00, 2'h0);
  endtask : addrOnlyCases

  task automatic pushCases();
    loadLine();
    chk({7'h00, wbReady}, 8'h01);
    run(5'h04, 3'h0, 5'h18, 3'h0, 8'h11, 2'h1);
    chk(seenAttr, 8'h13);
    chk(lastWord, 8'h03);
    slowGrant = 1'b1;
    loadLine();
    run(5'h00, 3'h0, 5'h18, 3'h0, 8'h09, 2'h1);
    chk(lastWord, 8'h03);
    run(5'h04, 3'h0, 5'h18, 3'h1, 8'h00, 2'h1);
  endtask : pushCases

  task automatic endOfTest();
    $display("Comparisons %0d, mismatches %0d", samplesChecked, fails);
    if (fails == 0 && samplesChecked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : endOfTest

  initial begin
    {reset, clr} = 2'h3;
    {fillDone, wbValid, slowGrant} = 3'h0;
    {pins, tagLookup, wbData, fails, samplesChecked, cycles} = '0;
    repeat (20) @(negedge clock);
    reset = 1'b0;
    readCases();
    writeCases();
    addrOnlyCases();
    pushCases();
    endOfTest();
  end
endmodule : testbench
